// file: shared/css_defs.svh
// Constants for the command source selector: offsets, fields, resets and timing.
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH
// ==========================================================================
// Timing
`define CSS_CLK_PERIOD_NS 20
`define CSS_MS_NS 1000000
`define CSS_MS_CYC (`CSS_MS_NS / `CSS_CLK_PERIOD_NS)
`define CSS_SEC_NS 1000000000
`define CSS_SEC_CYC (`CSS_SEC_NS / `CSS_CLK_PERIOD_NS)
`define CSS_AD_LIMIT_MULT 18'd3
// ==========================================================================
// Overload prevention rate codes, in units of 0.01 Hz/s.
`define CSS_OLP_USE_DECEL 17'd0
`define CSS_OLP_MAX 17'd10000
`define CSS_OLP_OFF 17'd99900
// ==========================================================================
// Register word addresses
`define CSS_A_CTRL 4'h0
`define CSS_A_DECEL 4'h1
`define CSS_A_OLP 4'h2
`define CSS_A_FMAX 4'h3
`define CSS_A_STATUS 4'h4
`define CSS_A_MASK 4'h5
`define CSS_A_STATE 4'h6
`define CSS_A_PRESET 4'h7
// ==========================================================================
// Control register fields
`define CSS_C_LM 3:0
`define CSS_C_FBM 5:4
`define CSS_C_LE_ASG 6
`define CSS_C_AD_EN 7
`define CSS_C_RUN_TERM 8
`define CSS_C_FSET2 9
// ==========================================================================
// Event bits and reset values
`define CSS_EV_AD_START 0
`define CSS_EV_AD_CANCEL 1
`define CSS_EV_OLP 2
`define CSS_EV_SRC 3
`define CSS_RST_CTRL 10'h000
`define CSS_RST_DECEL 16'd2000
`define CSS_RST_OLP `CSS_OLP_OFF
`define CSS_RST_FMAX 16'd5000
`define CSS_RST_PRESET 32'h0000_0000
`endif

// file: shared/css_pkg.sv
// Types shared by the command source selector files.
package css_pkg;
    // Where a command is taken from.
    typedef enum logic [1:0] {
        CSS_SRC_LOCAL,
        CSS_SRC_STD,
        CSS_SRC_OPT,
        CSS_SRC_FB
    } css_src_t;
    // Automatic deceleration episode state.
    typedef enum logic [1:0] {
        CSS_AD_OFF,
        CSS_AD_HOLD,
        CSS_AD_CANCEL
    } css_ad_t;
endpackage

// file: design/css_ramp.sv
// Output frequency ramp with automatic deceleration and overload prevention.
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.svh"
module css_ramp import css_pkg::*; #(
    parameter int unsigned MS_CYC = `CSS_MS_CYC, // Cycles per millisecond.
    parameter int unsigned SEC_CYC = `CSS_SEC_CYC // Cycles per second.
) (
    input wire logic sys_clk_in, // Control clock.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic [15:0] target_in, // Commanded frequency, 0.01 Hz.
    input wire logic run_in, // Run command.
    input wire logic [15:0] fmax_in, // Maximum frequency, 0.01 Hz.
    input wire logic [15:0] decel_ms_in, // First deceleration time, ms.
    input wire logic [16:0] olp_rate_in, // Overload prevention rate.
    input wire logic ad_en_in, // Automatic deceleration enable.
    input wire logic bus_over_in, // DC bus above threshold, synced.
    input wire logic olp_warn_in, // Overload imminent, synced.
    output logic [15:0] freq_out, // Output frequency.
    output logic ad_active_out, // Automatic deceleration holding.
    output logic ad_start_out, // Pulse: episode began.
    output logic ad_cancel_out, // Pulse: episode cancelled.
    output logic olp_active_out // Overload prevention lowering.
);
    logic [15:0] freq_r;
    logic [32:0] acc_r;
    logic [31:0] tick_r;
    logic [17:0] ad_ms_r;
    css_ad_t ad_r;
    logic [15:0] tgt;
    logic olp_on, down, up, rate_mode, hold, step;
    logic [32:0] num, den, acc_sum;
    logic [17:0] ad_limit;

    // ======================================================================
    // Ramp direction and rate selection.
    assign tgt = run_in ? ((target_in > fmax_in) ? fmax_in : target_in) : 16'h0000;
    assign olp_on = olp_warn_in && (olp_rate_in != `CSS_OLP_OFF) && (freq_r != 16'h0000);
    assign down = olp_on || (freq_r > tgt);
    assign up = !olp_on && (freq_r < tgt);
    assign rate_mode = olp_on && (olp_rate_in != `CSS_OLP_USE_DECEL);
    assign num = rate_mode ? {16'h0000, (olp_rate_in > `CSS_OLP_MAX) ? `CSS_OLP_MAX : olp_rate_in}
                           : {17'h00000, fmax_in};
    // A zero time would divide by nothing, so it steps every cycle instead.
    assign den = rate_mode ? 33'(SEC_CYC)
               : ((decel_ms_in == 16'h0000) ? 33'h1 : 33'(decel_ms_in) * 33'(MS_CYC));
    assign hold = down && ad_en_in && bus_over_in && (ad_r != CSS_AD_CANCEL);
    assign acc_sum = acc_r + num;
    assign step = (down || up) && !hold && (acc_sum >= den);
    assign ad_limit = `CSS_AD_LIMIT_MULT * {2'b00, decel_ms_in};

    // Step accumulator, frozen during an automatic deceleration hold. The backlog is capped
    // below one step, so a fast ramp leaves no debt for a slower rate after it.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !(down || up)) begin
            acc_r <= '0;
        end else if (!hold) begin
            acc_r <= !step ? acc_sum : (acc_sum - den >= den) ? den - 33'h1 : acc_sum - den;
        end
    end

    // Output frequency moves one 0.01 Hz unit per step.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            freq_r <= 16'h0000;
        end else if (step) begin
            freq_r <= down ? freq_r - 16'h0001 : freq_r + 16'h0001;
        end
    end

    // Free millisecond tick for the episode timer.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || tick_r == MS_CYC - 1) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + 32'd1;
        end
    end

    // Episode timer and state; a stuck episode gives way to plain ramping.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ad_r <= CSS_AD_OFF;
            ad_ms_r <= '0;
        end else begin
            unique case (ad_r)
                CSS_AD_OFF: begin
                    ad_ms_r <= '0;
                    if (hold) begin
                        ad_r <= CSS_AD_HOLD;
                    end
                end
                CSS_AD_HOLD: begin
                    if (tick_r == MS_CYC - 1) begin
                        ad_ms_r <= ad_ms_r + 18'd1;
                    end
                    if (!down) begin
                        ad_r <= CSS_AD_OFF;
                    end else if (ad_ms_r >= ad_limit) begin
                        ad_r <= CSS_AD_CANCEL;
                    end
                end
                CSS_AD_CANCEL: begin
                    if (!down) begin
                        ad_r <= CSS_AD_OFF;
                    end
                end
            endcase
        end
    end

    assign freq_out = freq_r;
    assign ad_active_out = (ad_r == CSS_AD_HOLD);
    assign ad_start_out = (ad_r == CSS_AD_OFF) && hold;
    assign ad_cancel_out = (ad_r == CSS_AD_HOLD) && down && (ad_ms_r >= ad_limit);
    assign olp_active_out = olp_on;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    chk_ad_disabled: assert property (!ad_en_in && ad_r == CSS_AD_OFF |=> !ad_active_out)
        else $error("auto decel engaged while disabled");
    chk_ad_hold_freq: assert property (hold |=> freq_r == $past(freq_r))
        else $error("frequency moved during bus voltage hold");
    chk_ad_cancel: assert property (ad_r == CSS_AD_HOLD && down && ad_ms_r >= ad_limit
        |=> ad_r == CSS_AD_CANCEL)
        else $error("auto decel not cancelled after limit");
    chk_olp_lower: assert property (olp_on |=> freq_r <= $past(freq_r))
        else $error("frequency rose during overload prevention");
    chk_olp_decel_t: assert property (olp_on && olp_rate_in == `CSS_OLP_USE_DECEL
        |-> den == ((decel_ms_in == 16'h0000) ? 33'h1 : 33'(decel_ms_in) * 33'(MS_CYC)))
        else $error("zero rate does not use first decel time");
    chk_olp_rate: assert property (rate_mode && olp_rate_in <= `CSS_OLP_MAX
        |-> num == {16'h0000, olp_rate_in} && den == 33'(SEC_CYC))
        else $error("overload rate not applied");
    chk_olp_off: assert property (olp_rate_in == `CSS_OLP_OFF |-> !olp_active_out)
        else $error("overload prevention active while disabled");
    cov_ad_cancel: cover property (ad_r == CSS_AD_HOLD ##1 ad_r == CSS_AD_CANCEL);
    cov_olp: cover property (olp_on && rate_mode ##1 step);
endmodule
`default_nettype wire

// file: design/css_top.sv
// Command source selector: chooses frequency and run sources, ramps output.
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.svh"
// ==========================================================================
module css_top import css_pkg::*; #(
    parameter int unsigned MS_CYC = `CSS_MS_CYC, // Cycles per millisecond.
    parameter int unsigned SEC_CYC = `CSS_SEC_CYC // Cycles per second.
) (
    input wire logic sys_clk_in, // Control clock, 50 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic [3:0] reg_addr_in, // Register word address.
    input wire logic [31:0] reg_wdata_in, // Register write data.
    input wire logic reg_wr_in, // Write strobe.
    input wire logic reg_rd_in, // Read strobe.
    output logic [31:0] reg_rdata_out, // Read data, cycle after strobe.
    output logic irq_out, // Interrupt, level, active high.
    input wire logic local_enable_input_in, // Local enable pin.
    input wire logic term_run_in, // Run terminal pin.
    input wire logic [1:0] mstep_sel_in, // Multistep frequency pins.
    input wire logic bus_over_in, // DC bus over threshold pin.
    input wire logic olp_warn_in, // Overload imminent pin.
    input wire logic [15:0] freq_set1_in, // Frequency setting 1 value.
    input wire logic [15:0] freq_set2_in, // Frequency setting 2 value.
    input wire logic keypad_run_in, // Keypad run key state.
    input wire logic [15:0] kp_link_freq_in, // Standard link frequency.
    input wire logic kp_link_run_in, // Standard link run.
    input wire logic [15:0] opt_link_freq_in, // Option card frequency.
    input wire logic opt_link_run_in, // Option card run.
    input wire logic [15:0] fb_freq_in, // Fieldbus frequency.
    input wire logic fb_run_in, // Fieldbus run.
    output logic [15:0] freq_cmd_out, // Selected frequency command.
    output logic run_cmd_out, // Selected run command.
    output logic [1:0] freq_src_out, // Frequency source code.
    output logic [1:0] run_src_out, // Run source code.
    output logic kp_port_link_out, // Keypad port serves standard link.
    output logic [15:0] out_freq_out, // Ramped output frequency.
    output logic ad_active_out, // Automatic deceleration holding.
    output logic olp_active_out // Overload prevention lowering.
);
    logic [9:0] ctrl_r;
    logic [15:0] decel_r;
    logic [16:0] olp_r;
    logic [15:0] fmax_r;
    logic [31:0] preset_r;
    logic [3:0] sts_r, mask_r, sts_nxt, ev;
    logic [31:0] rdata_r;
    logic [5:0] meta_r, sync_r;
    css_src_t fsrc_r, rsrc_r, fsrc_nxt, rsrc_nxt;
    logic [15:0] freq_cmd_r, local_freq;
    logic run_cmd_r, local_run, kp_link_r;
    logic [3:0] lm;
    logic [1:0] fbm, mstep;
    logic le_sync, term_sync, bus_sync, olp_sync, forced;
    logic ad_start, ad_cancel, olp_prev_r;

    // ======================================================================
    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else begin
            meta_r <= {olp_warn_in, bus_over_in, mstep_sel_in, term_run_in,
                       local_enable_input_in};
            sync_r <= meta_r;
        end
    end
    assign le_sync = sync_r[0];
    assign term_sync = sync_r[1];
    assign mstep = sync_r[3:2];
    assign bus_sync = sync_r[4];
    assign olp_sync = sync_r[5];

    // ======================================================================
    // Mode decode helpers.
    function automatic css_src_t lm_fsrc(input logic [3:0] m);
        case (m)
            4'h1, 4'h3, 4'h7: lm_fsrc = CSS_SRC_STD;
            4'h4, 4'h5, 4'h8: lm_fsrc = CSS_SRC_OPT;
            default: lm_fsrc = CSS_SRC_LOCAL;
        endcase
    endfunction

    function automatic css_src_t lm_rsrc(input logic [3:0] m);
        case (m)
            4'h2, 4'h3, 4'h5: lm_rsrc = CSS_SRC_STD;
            4'h6, 4'h7, 4'h8: lm_rsrc = CSS_SRC_OPT;
            default: lm_rsrc = CSS_SRC_LOCAL;
        endcase
    endfunction

    assign lm = ctrl_r[`CSS_C_LM];
    assign fbm = ctrl_r[`CSS_C_FBM];
    // An unassigned local-enable input never forces local control.
    assign forced = ctrl_r[`CSS_C_LE_ASG] && !le_sync;

    // ======================================================================
    // Source selection, evaluated fresh every cycle.
    always_comb begin
        if (forced) begin
            fsrc_nxt = CSS_SRC_LOCAL;
            rsrc_nxt = CSS_SRC_LOCAL;
        end else begin
            // Fieldbus bits replace only the command they name.
            fsrc_nxt = fbm[0] ? CSS_SRC_FB : lm_fsrc(lm);
            rsrc_nxt = fbm[1] ? CSS_SRC_FB : lm_rsrc(lm);
        end
    end

    // Local sources: multistep pins take priority over the settings.
    always_comb begin
        unique case (mstep)
            2'd0: local_freq = ctrl_r[`CSS_C_FSET2] ? freq_set2_in : freq_set1_in;
            2'd1: local_freq = preset_r[15:0];
            2'd2: local_freq = preset_r[31:16];
            2'd3: local_freq = fmax_r;
        endcase
    end
    assign local_run = ctrl_r[`CSS_C_RUN_TERM] ? term_sync : keypad_run_in;

    // Registered command outputs; a mode change shows one cycle later.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            fsrc_r <= CSS_SRC_LOCAL;
            rsrc_r <= CSS_SRC_LOCAL;
            freq_cmd_r <= 16'h0000;
            run_cmd_r <= 1'b0;
            kp_link_r <= 1'b0;
        end else begin
            fsrc_r <= fsrc_nxt;
            rsrc_r <= rsrc_nxt;
            unique case (fsrc_nxt)
                CSS_SRC_LOCAL: freq_cmd_r <= local_freq;
                CSS_SRC_STD: freq_cmd_r <= kp_link_freq_in;
                CSS_SRC_OPT: freq_cmd_r <= opt_link_freq_in;
                CSS_SRC_FB: freq_cmd_r <= fb_freq_in;
            endcase
            unique case (rsrc_nxt)
                CSS_SRC_LOCAL: run_cmd_r <= local_run;
                CSS_SRC_STD: run_cmd_r <= kp_link_run_in;
                CSS_SRC_OPT: run_cmd_r <= opt_link_run_in;
                CSS_SRC_FB: run_cmd_r <= fb_run_in;
            endcase
            // The keypad port carries the standard link while it is in use.
            kp_link_r <= (fsrc_nxt == CSS_SRC_STD) || (rsrc_nxt == CSS_SRC_STD);
        end
    end

    // ======================================================================
    // Ramp, automatic deceleration and overload prevention.
    css_ramp #(
        .MS_CYC(MS_CYC),
        .SEC_CYC(SEC_CYC)
    ) u_ramp (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .target_in(freq_cmd_r),
        .run_in(run_cmd_r),
        .fmax_in(fmax_r),
        .decel_ms_in(decel_r),
        .olp_rate_in(olp_r),
        .ad_en_in(ctrl_r[`CSS_C_AD_EN]),
        .bus_over_in(bus_sync),
        .olp_warn_in(olp_sync),
        .freq_out(out_freq_out),
        .ad_active_out(ad_active_out),
        .ad_start_out(ad_start),
        .ad_cancel_out(ad_cancel),
        .olp_active_out(olp_active_out)
    );

    // ======================================================================
    // Words: 0 control, 1 first deceleration time in ms, 2 overload rate.
    // Then 3 maximum frequency, 4 status, 5 mask, 6 live state, 7 presets.
    // Control: link mode 3:0, fieldbus mode 5:4, pin assigned 6, auto decel 7.
    // Bit 8 takes the local run from the terminal, bit 9 selects setting 2.
    // Narrow fields simply drop the upper write bits.
    // Status and state ignore writes, so software cannot fake an event.
    // Configuration registers written by software.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ctrl_r <= `CSS_RST_CTRL;
            decel_r <= `CSS_RST_DECEL;
            olp_r <= `CSS_RST_OLP;
            fmax_r <= `CSS_RST_FMAX;
            preset_r <= `CSS_RST_PRESET;
            mask_r <= 4'h0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `CSS_A_CTRL: ctrl_r <= reg_wdata_in[9:0];
                `CSS_A_DECEL: decel_r <= reg_wdata_in[15:0];
                `CSS_A_OLP: olp_r <= reg_wdata_in[16:0];
                `CSS_A_FMAX: fmax_r <= reg_wdata_in[15:0];
                `CSS_A_MASK: mask_r <= reg_wdata_in[3:0];
                `CSS_A_PRESET: preset_r <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Sticky events; a read clears them, but a new event in that cycle wins.
    assign ev[`CSS_EV_AD_START] = ad_start;
    assign ev[`CSS_EV_AD_CANCEL] = ad_cancel;
    // The onset alone raises the event; a held warning must not refill status.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            olp_prev_r <= 1'b0;
        end else begin
            olp_prev_r <= olp_active_out;
        end
    end
    assign ev[`CSS_EV_OLP] = olp_active_out && !olp_prev_r;
    assign ev[`CSS_EV_SRC] = (fsrc_nxt != fsrc_r) || (rsrc_nxt != rsrc_r);
    assign sts_nxt = ((reg_rd_in && reg_addr_in == `CSS_A_STATUS) ? 4'h0 : sts_r) | ev;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sts_r <= 4'h0;
        end else begin
            sts_r <= sts_nxt;
        end
    end
    assign irq_out = |(sts_r & mask_r);

    // Read data stands only in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !reg_rd_in) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            case (reg_addr_in)
                `CSS_A_CTRL: rdata_r <= {22'h000000, ctrl_r};
                `CSS_A_DECEL: rdata_r <= {16'h0000, decel_r};
                `CSS_A_OLP: rdata_r <= {15'h0000, olp_r};
                `CSS_A_FMAX: rdata_r <= {16'h0000, fmax_r};
                `CSS_A_STATUS: rdata_r <= {28'h0000000, sts_r};
                `CSS_A_MASK: rdata_r <= {28'h0000000, mask_r};
                `CSS_A_STATE: rdata_r <= {8'h00, olp_active_out, ad_active_out, run_cmd_r,
                                          kp_link_r, rsrc_r, fsrc_r, out_freq_out};
                `CSS_A_PRESET: rdata_r <= preset_r;
                default: rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rdata_out = rdata_r;
    assign freq_cmd_out = freq_cmd_r;
    assign run_cmd_out = run_cmd_r;
    assign freq_src_out = fsrc_r;
    assign run_src_out = rsrc_r;
    assign kp_port_link_out = kp_link_r;

    // ======================================================================
    // Checks.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    // Sources follow the mode codes one cycle later.
    chk_freq_map: assert property (!forced && !fbm[0]
        |=> freq_src_out == lm_fsrc($past(lm)))
        else $error("frequency source does not match link mode");

    chk_run_map: assert property (!forced && !fbm[1]
        |=> run_src_out == lm_rsrc($past(lm)))
        else $error("run source does not match link mode");

    chk_fb_both: assert property (!forced && fbm == 2'd3
        |=> freq_src_out == CSS_SRC_FB && run_src_out == CSS_SRC_FB)
        else $error("fieldbus mode 3 did not take both commands");

    chk_fb_run: assert property (!forced && fbm == 2'd2
        |=> run_src_out == CSS_SRC_FB && freq_src_out != CSS_SRC_FB)
        else $error("fieldbus mode 2 took the wrong commands");

    chk_fb_named_only: assert property (!forced && fbm == 2'd1
        |=> freq_src_out == CSS_SRC_FB && run_src_out != CSS_SRC_FB)
        else $error("fieldbus took a command it does not name");

    // The local-enable pin gates both mode selections.
    chk_le_honour: assert property (ctrl_r[`CSS_C_LE_ASG] && le_sync && fbm == 2'd2
        |=> run_src_out == CSS_SRC_FB)
        else $error("active local enable did not honour modes");

    chk_le_forced: assert property (forced
        |=> freq_src_out == CSS_SRC_LOCAL && run_src_out == CSS_SRC_LOCAL)
        else $error("inactive local enable did not force local");

    // Each command is the value that its chosen source offered.
    chk_local_freq: assert property (fsrc_nxt == CSS_SRC_LOCAL && mstep == 2'd0
        && !ctrl_r[`CSS_C_FSET2] |=> freq_cmd_out == $past(freq_set1_in))
        else $error("local frequency not taken from setting 1");

    chk_local_run: assert property (rsrc_nxt == CSS_SRC_LOCAL
        && !ctrl_r[`CSS_C_RUN_TERM] |=> run_cmd_out == $past(keypad_run_in))
        else $error("local run not taken from keypad");

    chk_opt_freq: assert property (fsrc_nxt == CSS_SRC_OPT
        |=> freq_cmd_out == $past(opt_link_freq_in))
        else $error("option frequency not selected");

    chk_fb_freq: assert property (fsrc_nxt == CSS_SRC_FB
        |=> freq_cmd_out == $past(fb_freq_in))
        else $error("fieldbus frequency not selected");

    chk_kp_port: assert property (fsrc_nxt == CSS_SRC_STD
        |=> kp_port_link_out && freq_cmd_out == $past(kp_link_freq_in))
        else $error("standard link not carried on keypad port");

    chk_std_run: assert property (rsrc_nxt == CSS_SRC_STD
        |=> run_cmd_out == $past(kp_link_run_in))
        else $error("standard link run not selected");

    // Source changes act next cycle and leave a sticky event.
    chk_reeval: assert property ($changed(fsrc_nxt) |=> $changed(freq_src_out))
        else $error("source change not applied next cycle");

    chk_src_event: assert property (ev[`CSS_EV_SRC]
        |=> sts_r[`CSS_EV_SRC])
        else $error("source change event lost");

    cov_fb_both: cover property (!forced && fbm == 2'd3 ##1 run_cmd_out);
    cov_forced: cover property (ctrl_r[`CSS_C_LE_ASG] && le_sync ##1 forced);
    cov_irq: cover property (ev[`CSS_EV_AD_START] ##1 irq_out);
endmodule
`default_nettype wire

// file: verif/css_host_model.sv
// Host side model that sends commands over the links.
`timescale 1ns/1ps
`default_nettype none
module css_host_model (
    input wire logic [15:0] seed_in, // Pattern seed.
    output logic [15:0] kp_f_out, // Standard link frequency.
    output logic [15:0] opt_f_out, // Option card frequency.
    output logic [15:0] fb_f_out, // Fieldbus frequency.
    output logic [2:0] run_out // Run: fieldbus, option, standard.
);
    // Each source differs, so that a wrong choice shows.
    assign kp_f_out = seed_in ^ 16'h1234;
    assign opt_f_out = seed_in ^ 16'h4321;
    assign fb_f_out = ~seed_in;
    assign run_out = seed_in[10:8];
endmodule
`default_nettype wire

// file: verif/css_top_test.sv
// Self-checking bench for the command source selector.
`timescale 1ns/1ps
`default_nettype none
module css_top_test import css_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, le = 1'b0, warn = 1'b0;
    logic kr = 1'b0, bov = 1'b0, irq, run, kpl, olp, ada;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, got;
    logic [15:0] seed = 16'h69a7, fs1 = 16'h0, kpf, opf, fbf, freq, ofreq;
    logic [2:0] runs;
    logic [1:0] fsrc, rsrc;
    int failures = 0, n_compared = 0;
    always #10 clk = ~clk;
    css_host_model u_host (.seed_in(seed), .kp_f_out(kpf), .opt_f_out(opf),
        .fb_f_out(fbf), .run_out(runs));
    css_top #(.MS_CYC(10), .SEC_CYC(1000)) u_dut (.sys_clk_in(clk), .rst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_rdata_out(rdata), .irq_out(irq), .local_enable_input_in(le),
        .term_run_in(1'b0), .mstep_sel_in(2'h0), .bus_over_in(bov), .olp_warn_in(warn),
        .freq_set1_in(fs1), .freq_set2_in(opf), .keypad_run_in(kr),
        .kp_link_freq_in(kpf), .kp_link_run_in(runs[0]), .opt_link_freq_in(opf),
        .opt_link_run_in(runs[1]), .fb_freq_in(fbf), .fb_run_in(runs[2]),
        .freq_cmd_out(freq), .run_cmd_out(run), .freq_src_out(fsrc), .run_src_out(rsrc),
        .kp_port_link_out(kpl), .out_freq_out(ofreq), .ad_active_out(ada), .olp_active_out(olp));
    // Pseudo-random pattern step.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Expected frequency and run sources; codes 9 to 15 behave as 0.
    function automatic logic [3:0] exp_src(input logic [6:0] c, input logic l);
        logic [1:0] f, r;
        f = c[3:0] inside {4'h1, 4'h3, 4'h7} ? 2'h1 : c[3:0] inside {4'h4, 4'h5, 4'h8} ? 2'h2 : 2'h0;
        r = c[3:0] inside {4'h2, 4'h3, 4'h5} ? 2'h1 : c[3:0] inside {4'h6, 4'h7, 4'h8} ? 2'h2 : 2'h0;
        f = c[4] ? 2'h3 : f;
        r = c[5] ? 2'h3 : r;
        return (c[6] & ~l) ? 4'h0 : {f, r};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Bus cycles; read data are taken in the one cycle they stand.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic report_and_stop();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog sized well above the expected run of under a thousand cycles.
    initial begin
        repeat (8000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    // ======================================================================
    // Main sequence
    initial begin
        logic [3:0] adr [4] = '{4'h1, 4'h2, 4'h3, 4'hf};
        logic [31:0] rv [4] = '{32'h7d0, 32'h1863c, 32'h1388, 32'h0};
        logic [15:0] fv [4];
        logic [3:0] e, rb;
        logic [6:0] c;
        logic l;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(adr[i], got);
            chk(got, rv[i]);
        end
        $display("test resets done");
        wr(4'h5, 32'h8);
        // Every link mode against every fieldbus mode, local enable at random.
        for (int i = 0; i < 64; i++) begin
            c = {seed[7], 2'(i), 4'(i >> 2)};
            l = seed[5] | seed[6];
            le <= l;
            fs1 <= seed;
            kr <= seed[3];
            seed <= lfsr(seed);
            wr(4'h0, {25'h0, c});
            repeat (5) @(posedge clk);
            e = exp_src(c, l);
            fv = '{fbf, opf, kpf, fs1};
            rb = {runs, kr};
            chk(fsrc, e[3:2]);
            chk(rsrc, e[1:0]);
            chk(freq, fv[3 - e[3:2]]);
            chk(run, rb[e[1:0]]);
            chk(kpl, e[3:2] == 2'h1 || e[1:0] == 2'h1);
        end
        $display("test sources done");
        rd(4'h4, got);
        wr(4'h0, 32'h3);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        rd(4'h4, got);
        chk(got, 32'h8);
        chk(irq, 1'b0);
        wr(4'h1, 32'h1);
        wr(4'h0, 32'h0);
        fs1 <= 16'h1000;
        kr <= 1'b1;
        repeat (50) @(posedge clk);
        warn <= 1'b1;
        repeat (5) @(posedge clk);
        chk(olp, 1'b0);
        wr(4'h2, 32'h64);
        repeat (2) @(posedge clk);
        chk(olp, 1'b1);
        fv[0] = ofreq;
        repeat (200) @(posedge clk);
        fv[1] = fv[0] - ofreq;
        chk(fv[1] inside {[16'd19:16'd21]}, 1'b1);
        $display("test overload done");
        warn <= 1'b0;
        bov <= 1'b1;
        kr <= 1'b0;
        wr(4'h0, 32'h80);
        repeat (4) @(posedge clk);
        fv[0] = ofreq;
        chk(ada, 1'b1);
        repeat (10) @(posedge clk);
        chk(ofreq, fv[0]);
        repeat (30) @(posedge clk);
        chk(ada, 1'b0);
        chk(ofreq < fv[0], 1'b1);
        $display("test auto decel done");
        report_and_stop();
    end
endmodule
`default_nettype wire
